/* hw/rbt_defs.svh */
`ifndef RBT_DEFS_SVH
`define RBT_DEFS_SVH

// ============================================================
// Register offsets
`define RBT_OFS_MAX_CYCLE_HIGH      8'h42
`define RBT_OFS_MAX_CYCLE_LOW       8'h44
`define RBT_OFS_B_RISE_DELAY        8'h45
`define RBT_OFS_MIN_CYCLE_HIGH      8'h46
`define RBT_OFS_B_FALL_OFFSET       8'h47
`define RBT_OFS_MIN_CYCLE_LOW       8'h48

// ============================================================
// Field positions
`define RBT_LIMIT_NIBBLE_MSB        7
`define RBT_LIMIT_NIBBLE_LSB        4
`define RBT_OFFSET_SIGN_BIT         7

// ============================================================
// Reset values
`define RBT_RST_MAX_CYCLE_HIGH      8'hFF
`define RBT_RST_MAX_CYCLE_LOW       8'hF0
`define RBT_RST_B_RISE_DELAY        8'h00
`define RBT_RST_MIN_CYCLE_HIGH      8'h00
`define RBT_RST_B_FALL_OFFSET       8'h00
`define RBT_RST_MIN_CYCLE_LOW       8'h00
`define RBT_RST_READ_DATA           8'h00

// ============================================================
// Timing
`define RBT_STEP_NS                 5
`define RBT_CLK_PERIOD_NS           10
`define RBT_STEPS_PER_CLK           (`RBT_CLK_PERIOD_NS / `RBT_STEP_NS)
`define RBT_OFFSET_WRAP             256

`endif

/* hw/rbt_pkg.sv */
package rbt_pkg;

	// ============================================================
	// Types
	typedef logic [7:0]  rbt_byte_t;
	typedef logic [11:0] rbt_limit_t;
	typedef logic [12:0] rbt_step_t;

	typedef enum logic [0:0]
	{
		RBT_IDLE,
		RBT_RUN
	} rbt_cycle_e;

endpackage : rbt_pkg

/* hw/rbt_timing_if.sv */
`timescale 1ns/1ps

interface rbt_timing_if;
	import rbt_pkg::*;

	rbt_step_t period;
	rbt_step_t rise;
	rbt_step_t fall;
	rbt_step_t midpoint;

	modport calc
	(
		output period,
		output rise,
		output fall,
		output midpoint
	);

	modport core
	(
		input  period,
		input  rise,
		input  fall,
		input  midpoint
	);

endinterface : rbt_timing_if

/* hw/rbt_edge_calc.sv */
`timescale 1ns/1ps
`include "rbt_defs.svh"

module rbt_edge_calc
	import rbt_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire rbt_byte_t  max_high,
	input  wire rbt_byte_t  max_low,
	input  wire rbt_byte_t  min_high,
	input  wire rbt_byte_t  min_low,
	input  wire rbt_byte_t  rise_code,
	input  wire rbt_byte_t  fall_code,
	input  wire rbt_limit_t period_req,
	rbt_timing_if.calc      timing
);

	localparam rbt_step_t STEPS = 13'(`RBT_STEPS_PER_CLK);

	rbt_limit_t max_cycle;
	rbt_limit_t min_cycle;
	rbt_limit_t clamped;
	rbt_step_t  period_next;
	rbt_step_t  mid_next;
	rbt_step_t  rise_next;
	rbt_step_t  fall_next;
	logic [13:0] fall_wide;
	logic [8:0]  lead;
	rbt_step_t  period_reg;
	rbt_step_t  mid_reg;
	rbt_step_t  rise_reg;
	rbt_step_t  fall_reg;

	// ============================================================
	// Limits and edges
	always_comb
	begin
		max_cycle = {max_high,
			max_low[`RBT_LIMIT_NIBBLE_MSB:`RBT_LIMIT_NIBBLE_LSB]}; // R1
		min_cycle = {min_high,
			min_low[`RBT_LIMIT_NIBBLE_MSB:`RBT_LIMIT_NIBBLE_LSB]}; // R4
		clamped = period_req;
		if (clamped < min_cycle) // R10
			clamped = min_cycle; // R5
		if (clamped > max_cycle) // R10
			clamped = max_cycle; // R2
		period_next = {1'b0, clamped}; // R3
		if (period_next < STEPS)
			period_next = STEPS;
		mid_next = {1'b0, period_next[12:1]};
		rise_next = {5'h00, rise_code}; // R6
		lead = 9'(`RBT_OFFSET_WRAP) - {1'b0, fall_code};
		if (fall_code[`RBT_OFFSET_SIGN_BIT]) // R8
		begin
			if ({4'h0, lead} > mid_next)
				fall_wide = 14'h0000;
			else
				fall_wide = {1'b0, mid_next} - {5'h00, lead}; // R8
		end
		else
			fall_wide = {1'b0, mid_next} + {6'h00, fall_code}; // R7
		if (fall_wide > {1'b0, period_next})
			fall_next = period_next;
		else
			fall_next = fall_wide[12:0];
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			period_reg <= 13'h0000;
			mid_reg    <= 13'h0000;
			rise_reg   <= 13'h0000;
			fall_reg   <= 13'h0000;
		end
		else
		begin
			period_reg <= period_next;
			mid_reg    <= mid_next;
			rise_reg   <= rise_next;
			fall_reg   <= fall_next;
		end
	end

	assign timing.period   = period_reg;
	assign timing.midpoint = mid_reg;
	assign timing.rise     = rise_reg;
	assign timing.fall     = fall_reg;

endmodule : rbt_edge_calc

/* hw/rbt_b_edge_timing.sv */
// Functional notes
// R1 - Low nibble register bits 7:4 are the maximum cycle's four LSBs.
// R2 - Maximum cycle is high byte times sixteen plus low nibble.
// R3 - Every limit step is 5 ns of switching period.
// R4 - Minimum cycle high register gives the eight MSBs.
// R5 - Minimum cycle is high byte times sixteen plus nibble, 5 ns steps.
// R6 - Rising edge delayed from cycle start by code times 5 ns.
// R7 - Falling edge placed from cycle midpoint by offset, 5 ns per step.
// R8 - Codes 0x00-0x7F trail midpoint; 0x80-0xFF lead by 256 minus code.
// R9 - Minimum cycle low register bits 7:4 are its four LSBs.
// R10 - Period kept within limits; low nibbles of the two limit low registers ignored.
`timescale 1ns/1ps
`include "rbt_defs.svh"

module rbt_b_edge_timing
	import rbt_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	output logic             REG_RD_VALID,
	input  wire logic        RESONANT_MODE,
	input  wire logic [11:0] PERIOD_REQ,
	output logic             SECOND_BRIDGE_DRIVE,
	output logic             CYCLE_START,
	output logic             CYCLE_MIDPOINT,
	output logic      [11:0] ACTIVE_PERIOD
);

	localparam rbt_step_t STEPS = 13'(`RBT_STEPS_PER_CLK);

	// ============================================================
	// Register file
	rbt_byte_t max_high_reg;
	rbt_byte_t max_high_next;
	rbt_byte_t max_low_reg;
	rbt_byte_t max_low_next;
	rbt_byte_t rise_reg;
	rbt_byte_t rise_next;
	rbt_byte_t min_high_reg;
	rbt_byte_t min_high_next;
	rbt_byte_t fall_ofs_reg;
	rbt_byte_t fall_ofs_next;
	rbt_byte_t min_low_reg;
	rbt_byte_t min_low_next;
	rbt_byte_t rdata_reg;
	rbt_byte_t rdata_next;
	logic      rvalid_reg;
	logic      rvalid_next;

	always_comb
	begin
		max_high_next = max_high_reg;
		max_low_next  = max_low_reg;
		rise_next     = rise_reg;
		min_high_next = min_high_reg;
		fall_ofs_next = fall_ofs_reg;
		min_low_next  = min_low_reg;
		if (REG_WR)
		begin
			unique case (REG_ADDR)
				`RBT_OFS_MAX_CYCLE_HIGH: max_high_next = REG_WDATA; // R2
				`RBT_OFS_MAX_CYCLE_LOW:  max_low_next  = REG_WDATA; // R1
				`RBT_OFS_B_RISE_DELAY:   rise_next     = REG_WDATA; // R6
				`RBT_OFS_MIN_CYCLE_HIGH: min_high_next = REG_WDATA; // R4
				`RBT_OFS_B_FALL_OFFSET:  fall_ofs_next = REG_WDATA; // R7
				`RBT_OFS_MIN_CYCLE_LOW:  min_low_next  = REG_WDATA; // R9
				default:
				begin
				end
			endcase
		end
		rvalid_next = REG_RD;
		rdata_next  = rdata_reg;
		if (REG_RD)
		begin
			unique case (REG_ADDR)
				`RBT_OFS_MAX_CYCLE_HIGH: rdata_next = max_high_reg;
				`RBT_OFS_MAX_CYCLE_LOW:  rdata_next = max_low_reg;
				`RBT_OFS_B_RISE_DELAY:   rdata_next = rise_reg;
				`RBT_OFS_MIN_CYCLE_HIGH: rdata_next = min_high_reg;
				`RBT_OFS_B_FALL_OFFSET:  rdata_next = fall_ofs_reg;
				`RBT_OFS_MIN_CYCLE_LOW:  rdata_next = min_low_reg;
				default:                 rdata_next = `RBT_RST_READ_DATA;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			max_high_reg <= `RBT_RST_MAX_CYCLE_HIGH;
			max_low_reg  <= `RBT_RST_MAX_CYCLE_LOW;
			rise_reg     <= `RBT_RST_B_RISE_DELAY;
			min_high_reg <= `RBT_RST_MIN_CYCLE_HIGH;
			fall_ofs_reg <= `RBT_RST_B_FALL_OFFSET;
			min_low_reg  <= `RBT_RST_MIN_CYCLE_LOW;
			rdata_reg    <= `RBT_RST_READ_DATA;
			rvalid_reg   <= 1'b0;
		end
		else
		begin
			max_high_reg <= max_high_next;
			max_low_reg  <= max_low_next;
			rise_reg     <= rise_next;
			min_high_reg <= min_high_next;
			fall_ofs_reg <= fall_ofs_next;
			min_low_reg  <= min_low_next;
			rdata_reg    <= rdata_next;
			rvalid_reg   <= rvalid_next;
		end
	end

	assign REG_RDATA    = rdata_reg;
	assign REG_RD_VALID = rvalid_reg;

	// ============================================================
	// Edge computation
	rbt_timing_if timing ();

	rbt_edge_calc u_calc
	(
		.clk_sys    (CLK_SYS),
		.nrst       (NRST),
		.max_high   (max_high_reg),
		.max_low    (max_low_reg),
		.min_high   (min_high_reg),
		.min_low    (min_low_reg),
		.rise_code  (rise_reg),
		.fall_code  (fall_ofs_reg),
		.period_req (PERIOD_REQ),
		.timing     (timing.calc)
	);

	// ============================================================
	// Switching cycle
	rbt_cycle_e state_reg;
	rbt_cycle_e state_next;
	rbt_step_t  cnt_reg;
	rbt_step_t  cnt_next;
	rbt_step_t  per_reg;
	rbt_step_t  per_next;
	rbt_step_t  mid_reg;
	rbt_step_t  mid_next;
	rbt_step_t  rise_at_reg;
	rbt_step_t  rise_at_next;
	rbt_step_t  fall_at_reg;
	rbt_step_t  fall_at_next;
	logic       drive_reg;
	logic       drive_next;
	logic       start_reg;
	logic       start_next;
	logic       midp_reg;
	logic       midp_next;
	logic [13:0] cnt_step;

	always_comb
	begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		per_next     = per_reg;
		mid_next     = mid_reg;
		rise_at_next = rise_at_reg;
		fall_at_next = fall_at_reg;
		start_next   = 1'b0;
		cnt_step     = {1'b0, cnt_reg} + {1'b0, STEPS};
		unique case (state_reg)
			RBT_IDLE:
			begin
				if (RESONANT_MODE)
				begin
					state_next   = RBT_RUN;
					cnt_next     = 13'h0000;
					per_next     = timing.period;
					mid_next     = timing.midpoint;
					rise_at_next = timing.rise;
					fall_at_next = timing.fall;
					start_next   = 1'b1;
				end
			end
			RBT_RUN:
			begin
				if (!RESONANT_MODE)
				begin
					state_next = RBT_IDLE;
					cnt_next   = 13'h0000;
				end
				else if (cnt_step >= {1'b0, per_reg}) // R10
				begin
					cnt_next     = 13'h0000;
					per_next     = timing.period; // R3
					mid_next     = timing.midpoint;
					rise_at_next = timing.rise;
					fall_at_next = timing.fall;
					start_next   = 1'b1;
				end
				else
					cnt_next = cnt_step[12:0];
			end
		endcase
		drive_next = (state_next == RBT_RUN)
			&& (cnt_next >= rise_at_next) // R6
			&& (cnt_next < fall_at_next); // R7
		midp_next = (state_next == RBT_RUN)
			&& (cnt_next >= mid_next)
			&& ({1'b0, cnt_next} < {1'b0, mid_next} + {1'b0, STEPS});
	end

	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			state_reg   <= RBT_IDLE;
			cnt_reg     <= 13'h0000;
			per_reg     <= 13'h0000;
			mid_reg     <= 13'h0000;
			rise_at_reg <= 13'h0000;
			fall_at_reg <= 13'h0000;
			drive_reg   <= 1'b0;
			start_reg   <= 1'b0;
			midp_reg    <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			per_reg     <= per_next;
			mid_reg     <= mid_next;
			rise_at_reg <= rise_at_next;
			fall_at_reg <= fall_at_next;
			drive_reg   <= drive_next;
			start_reg   <= start_next;
			midp_reg    <= midp_next;
		end
	end

	assign SECOND_BRIDGE_DRIVE = drive_reg;
	assign CYCLE_START         = start_reg;
	assign CYCLE_MIDPOINT      = midp_reg;
	assign ACTIVE_PERIOD       = per_reg[11:0];

endmodule : rbt_b_edge_timing

/* test/rbt_b_edge_timing_asserts.sv */
`timescale 1ns/1ps
module rbt_asserts
(
	input wire logic        CLK_SYS,
	input wire logic        NRST,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_RDATA,
	input wire logic        REG_RD_VALID,
	input wire logic        RESONANT_MODE,
	input wire logic        SECOND_BRIDGE_DRIVE,
	input wire logic        CYCLE_START,
	input wire logic        CYCLE_MIDPOINT,
	input wire logic [11:0] ACTIVE_PERIOD
);
	// ==========
	// Cycle tracking
	logic [11:0] cnt_reg, cnt_next, per_reg, per_next;
	logic        ok_reg, ok_next;
	always_comb
	begin
		cnt_next = CYCLE_START ? 12'h001 : cnt_reg + 12'h001;
		per_next = CYCLE_START ? ACTIVE_PERIOD : per_reg;
		ok_next  = RESONANT_MODE && (ok_reg || CYCLE_START);
	end
	always_ff @(posedge CLK_SYS or negedge NRST)
		if (!NRST)
		begin
			cnt_reg <= 12'h000;
			per_reg <= 12'h000;
			ok_reg  <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			per_reg <= per_next;
			ok_reg  <= ok_next;
		end
	// ==========
	// Checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	AST_RD_VALID: assert property (REG_RD |=> REG_RD_VALID)
		else $error("read valid missing");
	AST_RD_PULSE: assert property (REG_RD_VALID |-> $past(REG_RD))
		else $error("read valid without read");
	AST_RD_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data changed without read");
	AST_OFF_DRV: assert property (!RESONANT_MODE |=> !SECOND_BRIDGE_DRIVE)
		else $error("drive high outside resonant mode");
	AST_OFF_START: assert property (!RESONANT_MODE |=> !CYCLE_START)
		else $error("cycle start while idle");
	AST_ON_START: assert property ($rose(RESONANT_MODE) |=> CYCLE_START)
		else $error("no cycle start after enable");
	AST_PER_MIN: assert property (CYCLE_START |-> ACTIVE_PERIOD >= 12'h002)
		else $error("period below two steps");
	AST_LEN: assert property (CYCLE_START && ok_reg |->
		cnt_reg == 12'(({1'b0, per_reg} + 13'h0001) >> 1))
		else $error("cycle length wrong");
	AST_MID: assert property (CYCLE_MIDPOINT && ok_reg && per_reg > 12'h003 |->
		cnt_reg == ((per_reg >> 1) + 12'h001) >> 1)
		else $error("midpoint misplaced");
	cover property (CYCLE_START && ok_reg);
	cover property ($fell(SECOND_BRIDGE_DRIVE));
	cover property (REG_RD_VALID);
endmodule : rbt_asserts

/* test/rbt_gate_load.sv */
`timescale 1ns/1ps
module rbt_gate_load
(
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        drive,
	input  wire logic        start,
	input  wire logic        midpoint,
	output logic      [11:0] rise_at,
	output logic      [11:0] fall_at,
	output logic      [11:0] mid_at
);
	// ==========
	// Edge positions in clocks after cycle start
	logic [11:0] cnt;
	logic [11:0] pos;
	logic        drv_q;
	assign pos = start ? 12'h000 : cnt;
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			cnt     <= 12'h000;
			drv_q   <= 1'b0;
			rise_at <= 12'h000;
			fall_at <= 12'h000;
			mid_at  <= 12'h000;
		end
		else
		begin
			cnt   <= start ? 12'h001 : cnt + 12'h001;
			drv_q <= drive;
			if (drive && !drv_q)
				rise_at <= pos;
			if (!drive && drv_q)
				fall_at <= pos;
			if (midpoint)
				mid_at <= pos;
		end
endmodule : rbt_gate_load

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
	logic        clk   = 1'b0;
	logic        nrst  = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic        wr    = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic        rd    = 1'b0;
	logic        mode  = 1'b0;
	logic [11:0] preq  = 12'h190;
	logic [7:0]  rdata;
	logic        rvld, drv, start, midp;
	logic [11:0] aper, rise_at, fall_at, mid_at;
	int          n_fail  = 0;
	int          n_tests = 0;
	int          cyc     = 0;
	logic [7:0]  ra [6] = '{8'h42, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48};
	logic [7:0]  rv [6] = '{8'hFF, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  rc [4] = '{8'h01, 8'hFF, 8'h00, 8'h10};
	logic [7:0]  fc [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
	logic [11:0] er [4] = '{12'h001, 12'h080, 12'h000, 12'h008};
	logic [11:0] ef [4] = '{12'h064, 12'h0A4, 12'h024, 12'h064};
	always #5 clk = ~clk;
	rbt_b_edge_timing u_rbt_b_edge_timing
	(
		.CLK_SYS(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WR(wr),
		.REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
		.REG_RD_VALID(rvld), .RESONANT_MODE(mode), .PERIOD_REQ(preq),
		.SECOND_BRIDGE_DRIVE(drv), .CYCLE_START(start),
		.CYCLE_MIDPOINT(midp), .ACTIVE_PERIOD(aper)
	);
	rbt_gate_load u_rbt_gate_load
	(
		.clk_sys(clk), .nrst(nrst), .drive(drv), .start(start),
		.midpoint(midp), .rise_at(rise_at), .fall_at(fall_at),
		.mid_at(mid_at)
	);
	// ==========
	// Helpers
	task chk(string nm, logic [11:0] e, logic [11:0] s);
		n_tests++;
		if (s !== e)
		begin
			$display("unexpected %s exp %0h got %0h", nm, e, s);
			n_fail++;
		end
	endtask : chk
	task wreg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wreg
	task rreg(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		chk("rd_valid", 12'h001, 12'(rvld));
		chk("rd_data", 12'(e), 12'(rdata));
	endtask : rreg
	task wait_st(int n);
		repeat (n)
		begin
			@(posedge clk) #1;
			while (start !== 1'b1)
				@(posedge clk) #1;
		end
	endtask : wait_st
	task test_done;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	// ==========
	// Tests
	task t_regs;
		for (int i = 0; i < 6; i++)
			rreg(ra[i], rv[i]);
		for (int i = 0; i < 6; i++)
		begin
			wreg(ra[i], ~rv[i]);
			rreg(ra[i], ~rv[i]);
			wreg(ra[i], rv[i]);
		end
		wreg(8'h43, 8'h77);
		rreg(8'h43, 8'h00);
		$display("test regs done");
	endtask : t_regs
	task t_edges;
		@(posedge clk);
		mode <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			wreg(8'h45, rc[i]);
			wreg(8'h47, fc[i]);
			wait_st(3);
			chk("rise", er[i], rise_at);
			chk("fall", ef[i], fall_at);
			chk("mid", 12'h064, mid_at);
			chk("period", 12'h190, aper);
		end
		$display("test edges done");
	endtask : t_edges
	task t_clamp;
		wreg(8'h42, 8'h01);
		wreg(8'h44, 8'h4F);
		wait_st(3);
		chk("max", 12'h014, aper);
		wreg(8'h42, 8'hFF);
		wreg(8'h44, 8'hF0);
		wreg(8'h46, 8'h02);
		wreg(8'h48, 8'h3F);
		wreg(8'h45, 8'h00);
		wreg(8'h47, 8'h00);
		preq <= 12'h00A;
		wait_st(3);
		chk("min", 12'h023, aper);
		chk("drive_on", 12'h001, 12'(drv));
		@(posedge clk);
		mode <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("drive_off", 12'h000, 12'(drv));
		$display("test clamp done");
	endtask : t_clamp
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_edges();
		t_clamp();
		test_done();
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			test_done();
		end
	end
endmodule : tb
bind rbt_b_edge_timing rbt_asserts u_rbt_asserts
(
	.CLK_SYS(CLK_SYS), .NRST(NRST), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .REG_RD_VALID(REG_RD_VALID),
	.RESONANT_MODE(RESONANT_MODE), .CYCLE_START(CYCLE_START),
	.SECOND_BRIDGE_DRIVE(SECOND_BRIDGE_DRIVE),
	.CYCLE_MIDPOINT(CYCLE_MIDPOINT), .ACTIVE_PERIOD(ACTIVE_PERIOD)
);
